// ==== src/tcp_port.sv ====
`timescale 1ns/1ps
// Purpose: Command decoder behind the three-wire serial thermometer port
// Assumes: Serial clock is far slower than ref_clk and is sampled
// Notes:   Conversion engine is outside; this block issues start/stop
module tcp_port
    import tcp_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Three-wire pins
    input  wire logic       sel_in,      // Transfer select, high opens
    input  wire logic       sclk_in,     // Serial clock from host
    input  wire logic       dq_in,       // Data line level
    output logic            dq_out,      // Data line drive value
    output logic            dq_oe,       // Data line drive enable
    // Conversion engine side
    input  wire logic [8:0] temp_result, // Last completed conversion
    output logic            conv_start,  // One-cycle start pulse
    output logic            conv_stop,   // One-cycle stop pulse
    output logic            conv_run,    // Conversions enabled level
    // Stored settings
    output logic [8:0]      high_limit,
    output logic [8:0]      low_limit,
    output logic [7:0]      config_reg
);
    // ==========================================================
    // Synchronised pins
    logic sel_s;
    logic sclk_s;
    logic dq_s;

    tcp_sync u_sel  (.ref_clk(ref_clk), .rst(rst), .pin_in(sel_in),  .pin_sync(sel_s));
    tcp_sync u_sclk (.ref_clk(ref_clk), .rst(rst), .pin_in(sclk_in), .pin_sync(sclk_s));
    tcp_sync u_dq   (.ref_clk(ref_clk), .rst(rst), .pin_in(dq_in),   .pin_sync(dq_s));

    // ==========================================================
    // State record
    typedef struct packed {
        tcp_state_type st;
        logic          sclk_prev;  // Last sampled serial clock
        logic [3:0]    cnt;        // Bits handled in this phase
        logic [7:0]    cmd;        // Command shift register
        logic [8:0]    sh;         // Data shift register
        logic [3:0]    len;        // Data phase length
        logic          dq_o;       // Output bit
        logic          dq_e;       // Output enable
        logic [8:0]    hi;
        logic [8:0]    lo;
        logic [7:0]    cfg;
        logic          run;
        logic          start;
        logic          stop;
    } tcp_regs_type;

    tcp_regs_type cur_ff;
    tcp_regs_type nxt_ff;
    logic         rise;
    logic         fall;

    // Serial clock edges
    assign rise = sclk_s & ~cur_ff.sclk_prev;
    assign fall = ~sclk_s & cur_ff.sclk_prev;

    // ==========================================================
    // Next state
    always_comb
    begin
        nxt_ff           = cur_ff;
        nxt_ff.sclk_prev = sclk_s;
        nxt_ff.start     = 1'b0;
        nxt_ff.stop      = 1'b0;
        case (cur_ff.st)
            TCP_IDLE:
            begin
                nxt_ff.dq_e = 1'b0;
                if (sel_s)
                begin
                    nxt_ff.st  = TCP_CMD;
                    nxt_ff.cnt = TCP_CNT_ZERO;
                end
            end
            TCP_CMD:
            begin
                if (rise)
                begin
                    nxt_ff.cmd = {dq_s, cur_ff.cmd[7:1]};
                    nxt_ff.cnt = cur_ff.cnt + TCP_CNT_ONE;
                    if (cur_ff.cnt == TCP_CNT_CMD - TCP_CNT_ONE)
                    begin
                        nxt_ff.cnt = TCP_CNT_ZERO;
                        nxt_ff.st  = TCP_DONE;   // Start, stop and unknown codes end here
                        nxt_ff.sh  = 9'h000;
                        case ({dq_s, cur_ff.cmd[7:1]})
                            TCP_CMD_READ_TEMP:
                            begin
                                nxt_ff.st  = TCP_RD;
                                nxt_ff.sh  = temp_result;
                                nxt_ff.len = TCP_CNT_TEMP;
                            end
                            TCP_CMD_RD_HIGH:
                            begin
                                nxt_ff.st  = TCP_RD;
                                nxt_ff.sh  = cur_ff.hi;
                                nxt_ff.len = TCP_CNT_TEMP;
                            end
                            TCP_CMD_RD_LOW:
                            begin
                                nxt_ff.st  = TCP_RD;
                                nxt_ff.sh  = cur_ff.lo;
                                nxt_ff.len = TCP_CNT_TEMP;
                            end
                            TCP_CMD_RD_CONFIG:
                            begin
                                nxt_ff.st  = TCP_RD;
                                nxt_ff.sh  = {1'b0, cur_ff.cfg};
                                nxt_ff.len = TCP_CNT_CFG;
                            end
                            TCP_CMD_WR_HIGH, TCP_CMD_WR_LOW:
                            begin
                                nxt_ff.st  = TCP_WR;
                                nxt_ff.len = TCP_CNT_TEMP;
                            end
                            TCP_CMD_WR_CONFIG:
                            begin
                                nxt_ff.st  = TCP_WR;
                                nxt_ff.len = TCP_CNT_CFG;
                            end
                            TCP_CMD_START_CONV:
                            begin
                                nxt_ff.start = 1'b1;
                                nxt_ff.run   = 1'b1;
                            end
                            TCP_CMD_STOP_CONV:
                            begin
                                nxt_ff.stop = 1'b1;
                                nxt_ff.run  = 1'b0;
                            end
                            default:
                            begin
                                nxt_ff.st = TCP_DONE;
                            end
                        endcase
                    end
                end
            end
            TCP_WR:
            begin
                if (rise)
                begin
                    nxt_ff.cnt = cur_ff.cnt + TCP_CNT_ONE;
                    if (cur_ff.len == TCP_CNT_TEMP)
                    begin
                        nxt_ff.sh = {dq_s, cur_ff.sh[8:1]};
                    end
                    else
                    begin
                        nxt_ff.sh = {1'b0, dq_s, cur_ff.sh[7:1]};
                    end
                    if (cur_ff.cnt == cur_ff.len - TCP_CNT_ONE)
                    begin
                        nxt_ff.st = TCP_DONE;
                        if (cur_ff.cmd == TCP_CMD_WR_HIGH)
                        begin
                            nxt_ff.hi = {dq_s, cur_ff.sh[8:1]};
                        end
                        else if (cur_ff.cmd == TCP_CMD_WR_LOW)
                        begin
                            nxt_ff.lo = {dq_s, cur_ff.sh[8:1]};
                        end
                        else
                        begin
                            nxt_ff.cfg = {dq_s, cur_ff.sh[7:1]};
                        end
                    end
                end
            end
            TCP_RD:
            begin
                // Drive on falling edge, release while clock high
                if (fall)
                begin
                    nxt_ff.dq_o = cur_ff.sh[0];
                    nxt_ff.dq_e = 1'b1;
                    nxt_ff.sh   = {1'b0, cur_ff.sh[8:1]};
                end
                else if (rise && cur_ff.dq_e)
                begin
                    nxt_ff.dq_e = 1'b0;
                    nxt_ff.cnt  = cur_ff.cnt + TCP_CNT_ONE;
                    if (cur_ff.cnt == cur_ff.len - TCP_CNT_ONE)
                    begin
                        nxt_ff.st = TCP_DONE;
                    end
                end
            end
            TCP_DONE:
            begin
                nxt_ff.dq_e = 1'b0;
            end
            default:
            begin
                nxt_ff.st = TCP_IDLE;
            end
        endcase
        if (!sel_s)
        begin
            nxt_ff.st   = TCP_IDLE;
            nxt_ff.dq_e = 1'b0;
        end
    end

    // Register the record
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cur_ff     <= '0;
            cur_ff.st  <= TCP_IDLE;
            cur_ff.hi  <= TCP_LIMIT_RESET;
            cur_ff.lo  <= TCP_LIMIT_RESET;
            cur_ff.cfg <= TCP_CFG_RESET;
        end
        else
        begin
            cur_ff <= nxt_ff;
        end
    end

    // ==========================================================
    // Outputs
    assign dq_out     = cur_ff.dq_o;
    assign dq_oe      = cur_ff.dq_e;
    assign conv_start = cur_ff.start;
    assign conv_stop  = cur_ff.stop;
    assign conv_run   = cur_ff.run;
    assign high_limit = cur_ff.hi;
    assign low_limit  = cur_ff.lo;
    assign config_reg = cur_ff.cfg;

    // ==========================================================
    // Checks
    a_abort_release: assert property (@(posedge ref_clk) disable iff (rst)
        !sel_s |=> !dq_oe) else $error("data line driven after deselect");
    a_start_run: assert property (@(posedge ref_clk) disable iff (rst)
        conv_start |-> conv_run && !conv_stop) else $error("start without run");
    a_stop_run: assert property (@(posedge ref_clk) disable iff (rst)
        conv_stop |-> !conv_run) else $error("stop left run set");
    a_drive_readonly: assert property (@(posedge ref_clk) disable iff (rst)
        dq_oe |-> cur_ff.st == TCP_RD) else $error("driving outside read");
    a_release_high: assert property (@(posedge ref_clk) disable iff (rst)
        (sclk_s && !cur_ff.sclk_prev && dq_oe) |=> !dq_oe) else $error("drive held");
    a_limit_hold: assert property (@(posedge ref_clk) disable iff (rst)
        cur_ff.st != TCP_WR |=> $stable(high_limit)) else $error("limit changed");
    a_low_hold: assert property (@(posedge ref_clk) disable iff (rst)
        cur_ff.st != TCP_WR |=> $stable(low_limit)) else $error("low limit changed");
    a_cfg_hold: assert property (@(posedge ref_clk) disable iff (rst)
        cur_ff.st != TCP_WR |=> $stable(config_reg)) else $error("config changed");
    a_fresh_cmd: assert property (@(posedge ref_clk) disable iff (rst)
        (cur_ff.st == TCP_IDLE && sel_s) |=> cur_ff.st == TCP_CMD && cur_ff.cnt == TCP_CNT_ZERO)
        else $error("no fresh decode");
    c_read: cover property (@(posedge ref_clk) cur_ff.st == TCP_RD ##1 cur_ff.st == TCP_DONE);
    c_write: cover property (@(posedge ref_clk) cur_ff.st == TCP_WR ##1 cur_ff.st == TCP_DONE);
    c_start: cover property (@(posedge ref_clk) conv_start);
    c_abort: cover property (@(posedge ref_clk) cur_ff.st == TCP_RD ##1 cur_ff.st == TCP_IDLE);
endmodule // tcp_port

// ==== inc/tcp_pkg.sv ====
// Purpose: Constants and types of the three-wire thermometer command port
// Assumes: Port pins are sampled by ref_clk at 125 MHz
// Notes:   Command codes, field widths and timing counts live here
package tcp_pkg;
    // ==========================================================
    // Command codes
    localparam logic [7:0] TCP_CMD_READ_TEMP   = 8'haa;
    localparam logic [7:0] TCP_CMD_START_CONV  = 8'hee;
    localparam logic [7:0] TCP_CMD_STOP_CONV   = 8'h22;
    localparam logic [7:0] TCP_CMD_WR_HIGH     = 8'h01;
    localparam logic [7:0] TCP_CMD_WR_LOW      = 8'h02;
    localparam logic [7:0] TCP_CMD_RD_HIGH     = 8'ha1;
    localparam logic [7:0] TCP_CMD_RD_LOW      = 8'ha2;
    localparam logic [7:0] TCP_CMD_WR_CONFIG   = 8'h0c;
    localparam logic [7:0] TCP_CMD_RD_CONFIG   = 8'hac;
    // ==========================================================
    // Widths and counts
    localparam int         TCP_CMD_BITS   = 8;
    localparam int         TCP_TEMP_BITS  = 9;
    localparam logic [3:0] TCP_CNT_CMD    = 4'h8;   // Command clocks
    localparam logic [3:0] TCP_CNT_TEMP   = 4'h9;   // Nine-bit data clocks
    localparam logic [3:0] TCP_CNT_CFG    = 4'h8;   // Config data clocks
    localparam logic [3:0] TCP_CNT_ZERO   = 4'h0;
    localparam logic [3:0] TCP_CNT_ONE    = 4'h1;
    // ==========================================================
    // Config fields
    localparam int         TCP_CFG_ONESHOT = 0;     // One-shot bit
    localparam int         TCP_CFG_CPU     = 1;     // Host-controlled bit
    localparam logic [7:0] TCP_CFG_RESET   = 8'h0a; // Host mode set, one-shot clear
    localparam logic [8:0] TCP_LIMIT_RESET = 9'h000;
    // ==========================================================
    // Sequencer states
    typedef enum logic [2:0] {
        TCP_IDLE,   // Select low
        TCP_CMD,    // Collecting command byte
        TCP_WR,     // Collecting write data
        TCP_RD,     // Shifting read data out
        TCP_DONE    // Waiting for select low
    } tcp_state_type;
endpackage

// ==== src/tcp_sync.sv ====
`timescale 1ns/1ps
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to ref_clk
// Notes:   Output changes once stages two and three agree
module tcp_sync
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // Pin and result
    input  wire logic pin_in,
    output logic      pin_sync
);
    // ==========================================================
    // Stage registers
    logic [2:0] stage_ff;   // Shift chain
    logic       out_ff;     // Filtered level

    // Chain and agreement filter
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stage_ff <= 3'h0;
            out_ff   <= 1'b0;
        end
        else
        begin
            stage_ff <= {stage_ff[1:0], pin_in};
            // Only stages two and three are compared
            if (stage_ff[1] == stage_ff[2])
            begin
                out_ff <= stage_ff[2];
            end
        end
    end

    assign pin_sync = out_ff;
endmodule // tcp_sync

// ==== test/tcp_host.sv ====
// Purpose: Host model driving the three-wire port from the far side
// Assumes: Serial clock idles high, 125 ns period, data line pulled low
// Notes:   Storage settle wait is shortened by a parameter
`timescale 1ns/1ps
module tcp_host
#(
    parameter int NV_WAIT_NS = 2000   // Shortened storage settle time
)
(
    // Bench clock, used only to launch each transfer
    input  wire logic ref_clk,
    // Wire level seen by the host
    input  wire logic dq_wire,
    // Host drives
    output logic      sel,
    output logic      sclk,
    output logic      host_d,
    output logic      host_oe
);
    // ==========================================================
    // Idle levels
    initial
    begin
        sel     = 1'b0;
        sclk    = 1'b1;
        host_d  = 1'b0;
        host_oe = 1'b0;
    end

    // ==========================================================
    // One transfer: command, write bits, read bits, optional cut
    task automatic xfer(input logic [7:0] cmd, input logic [8:0] wdata, input int nw,
                        input int nr, input logic cut, output logic [8:0] rdata);
        rdata = 9'h000;
        // Launch off the sampling edge; half-ns steps then never meet it
        @(posedge ref_clk);
        #1.25;
        sel = 1'b1;
        #100;
        for (int i = 0; i < 8 + nw + nr; i++)
        begin
            sclk    = 1'b0;
            host_oe = (i < 8 + nw);
            host_d  = (i < 8) ? cmd[i] : ((i < 8 + nw) ? wdata[i - 8] : 1'b0);
            #62.5;
            if (cut && i == 7 + nw + nr)
            begin
                sel = 1'b0;
                #100;
            end
            sclk = 1'b1;
            if (i >= 8 + nw)
            begin
                rdata[i - 8 - nw] = dq_wire;
            end
            #62.5;
        end
        host_oe = 1'b0;
        sel = 1'b0;
        #250;
        if (nw > 0)
        begin
            #(NV_WAIT_NS);
        end
    endtask
endmodule // tcp_host

// ==== test/tcp_port_tb.sv ====
// Purpose: Self-checking bench of the three-wire command port
// Assumes: Host model supplies serial traffic
// Notes:   Each scenario is one task
`timescale 1ns/1ps
module tcp_port_tb;
    import tcp_pkg::*;
    // ==========================================================
    // Signals
    logic       ref_clk     = 1'b0;
    logic       rst         = 1'b1;
    logic [8:0] temp_result = 9'h1c3;
    logic       sel, sclk, host_d, host_oe, dq_out, dq_oe;
    logic       conv_start, conv_stop, conv_run;
    logic [8:0] high_limit, low_limit, d;
    logic [7:0] config_reg;
    logic       oe_q        = 1'b0;    // Previous drive enable
    logic       oe_late     = 1'b0;    // Drive outlived select
    int         oe_rises    = 0;       // Driven read bits
    int         start_cnt   = 0;
    int         stop_cnt    = 0;
    int         late_run    = 0;
    int         cycles      = 0;
    int         mismatches  = 0;
    int         num_checks  = 0;
    wire        dq_wire     = dq_oe ? dq_out : (host_oe ? host_d : 1'b0);

    // ==========================================================
    // Design, host and clock
    tcp_port DUT (.ref_clk(ref_clk), .rst(rst), .sel_in(sel), .sclk_in(sclk),
        .dq_in(dq_wire), .dq_out(dq_out), .dq_oe(dq_oe), .temp_result(temp_result),
        .conv_start(conv_start), .conv_stop(conv_stop), .conv_run(conv_run),
        .high_limit(high_limit), .low_limit(low_limit), .config_reg(config_reg));
    tcp_host H (.ref_clk(ref_clk), .dq_wire(dq_wire), .sel(sel), .sclk(sclk),
        .host_d(host_d), .host_oe(host_oe));
    always #4 ref_clk = ~ref_clk;

    // ==========================================================
    // Monitors and timeout
    always @(posedge ref_clk)
    begin
        oe_q     <= dq_oe;
        oe_rises <= oe_rises + int'(dq_oe && !oe_q);
        start_cnt <= start_cnt + int'(conv_start === 1'b1);
        stop_cnt <= stop_cnt + int'(conv_stop === 1'b1);
        late_run <= (!sel && dq_oe) ? late_run + 1 : 0;
        oe_late  <= oe_late || (late_run > 8);
        cycles   <= cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            give_verdict();
        end
    end

    // ==========================================================
    // Compare, read and verdict
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input int n, output logic [8:0] q);
        int r0;
        r0 = oe_rises;
        H.xfer(cmd, 9'h000, 0, n, 1'b0, q);
        chk(9'(oe_rises - r0), 9'(n));
    endtask
    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_cfg_reset();
        chk({1'b0, config_reg}, {1'b0, TCP_CFG_RESET});
        rd(TCP_CMD_RD_CONFIG, 8, d);
        chk(d, {1'b0, TCP_CFG_RESET});
    endtask
    task automatic t_temp();
        rd(TCP_CMD_READ_TEMP, 9, d);
        chk(d, 9'h1c3);
        @(posedge ref_clk);
        #1.25 temp_result = 9'h03c;
        rd(TCP_CMD_READ_TEMP, 9, d);
        chk(d, 9'h03c);
    endtask
    task automatic t_config();
        H.xfer(TCP_CMD_WR_CONFIG, 9'h002, 8, 0, 1'b0, d);
        chk({1'b0, config_reg}, 9'h002);
        chk({7'h00, config_reg[TCP_CFG_CPU], config_reg[TCP_CFG_ONESHOT]}, 9'h002);
        rd(TCP_CMD_RD_CONFIG, 8, d);
        chk(d, 9'h002);
    endtask
    task automatic t_limits();
        H.xfer(TCP_CMD_WR_HIGH, 9'h1a5, 9, 0, 1'b0, d);
        chk(high_limit, 9'h1a5);
        H.xfer(TCP_CMD_WR_LOW, 9'h014, 9, 0, 1'b0, d);
        chk(low_limit, 9'h014);
        rd(TCP_CMD_RD_HIGH, 9, d);
        chk(d, 9'h1a5);
        rd(TCP_CMD_RD_LOW, 9, d);
        chk(d, 9'h014);
    endtask
    task automatic t_conv();
        H.xfer(TCP_CMD_START_CONV, 9'h000, 0, 0, 1'b0, d);
        chk(9'(start_cnt), 9'h001);
        chk({8'h00, conv_run}, 9'h001);
        H.xfer(TCP_CMD_START_CONV, 9'h000, 0, 0, 1'b0, d);
        chk(9'(start_cnt), 9'h002);
        H.xfer(TCP_CMD_STOP_CONV, 9'h000, 0, 0, 1'b0, d);
        chk(9'(stop_cnt), 9'h001);
        chk({8'h00, conv_run}, 9'h000);
    endtask
    task automatic t_abort();
        int r0;
        H.xfer(TCP_CMD_WR_HIGH, 9'h0ff, 9, 0, 1'b1, d);
        chk(high_limit, 9'h1a5);
        r0 = oe_rises;
        H.xfer(TCP_CMD_RD_LOW, 9'h000, 0, 4, 1'b1, d);
        chk(9'(oe_rises - r0), 9'h004);
        chk({8'h00, oe_late}, 9'h000);
        rd(TCP_CMD_RD_LOW, 9, d);
        chk(d, 9'h014);
    endtask
    task automatic t_unknown();
        int r0;
        r0 = oe_rises;
        H.xfer(8'h55, 9'h1ff, 9, 0, 1'b0, d);
        chk(high_limit, 9'h1a5);
        chk(low_limit, 9'h014);
        chk({1'b0, config_reg}, 9'h002);
        chk(9'(oe_rises - r0), 9'h000);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1.25 rst = 1'b0;
        t_cfg_reset();
        t_limits();
        t_temp();
        t_conv();
        t_config();
        t_abort();
        t_unknown();
        give_verdict();
    end
endmodule // tcp_port_tb
